// File: rtl/gpr_port_register_file.sv
// GPIO port register file: per-pin aliases, direction, mask and port views.
// Assumes an AXI4-Lite master on aclk and asynchronous pad levels.
`timescale 1ns/1ps
`include "gpr_params.svh"

module gpr_port_register_file #(
    parameter logic PIN17_PRESENT = 1'b1
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [31:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [31:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pads
    input wire logic [17:0] pad_level,
    input wire logic [17:0] pad_analog_sel,
    output logic [17:0] pin_output_latch,
    output logic [17:0] pin_direction_out
);

    // Expand byte strobes to a bit mask; shared by every write path except the byte aliases
    function automatic logic [31:0] strobe_bits(input logic [3:0] strb);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++)
        begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction

    // Window hit and in-window offset of an address
    function automatic logic addr_hit(input logic [31:0] addr);
        return (addr & `GPR_WIN_MASK) == `GPR_BASE_ADDR;
    endfunction
    function automatic logic [13:0] addr_off(input logic [31:0] addr);
        return {addr[13:2], 2'h0};
    endfunction

    // Implemented pins
    wire gpr_pkg::gpr_pins_t impl_pins = {PIN17_PRESENT, `GPR_LOW_PINS_IMPL};

    // Pad synchroniser
    gpr_pkg::gpr_pins_t pad_meta;
    gpr_pkg::gpr_pins_t pad_sync;
    always_ff @(posedge aclk)
    begin
        pad_meta <= pad_level;
        pad_sync <= pad_meta;
    end

    // Live pin view, analog and absent pins forced low
    wire gpr_pkg::gpr_pins_t pin_view = pad_sync & ~pad_analog_sel & impl_pins;

    // Port state
    gpr_pkg::gpr_pins_t out_latch;
    gpr_pkg::gpr_pins_t pin_direction;
    gpr_pkg::gpr_pins_t access_mask;
    gpr_pkg::gpr_pins_t next_out_latch;
    gpr_pkg::gpr_pins_t next_pin_direction;
    gpr_pkg::gpr_pins_t next_access_mask;
    // Write channel holding
    logic aw_held;
    logic w_held;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    gpr_pkg::gpr_resp_t bresp;

    // Read channel
    logic rvalid;
    logic [31:0] rdata;
    gpr_pkg::gpr_resp_t rresp;
    logic [31:0] next_rdata;
    logic next_rd_hit;

    // Handshakes; address and data may arrive in either order
    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    assign s_axi_arready = !rvalid;
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire ar_take = s_axi_arvalid && s_axi_arready;
    // Write executes once both halves are held and the previous answer is gone
    wire do_write = aw_held && w_held && !bvalid;

    // Write decode
    wire wr_hit = addr_hit(aw_addr);
    wire [13:0] wr_off = addr_off(aw_addr);
    wire [31:0] wr_bits = strobe_bits(w_strb);
    wire [31:0] wr_val = w_data & wr_bits;
    wire [17:0] wr_val18 = wr_val[17:0];
    wire [17:0] wr_bits18 = wr_bits[17:0];
    wire wr_byte_rgn = wr_hit && wr_off <= `GPR_OFF_BYTE_LAST;
    wire wr_word_rgn = wr_hit && wr_off >= `GPR_OFF_WORD_FIRST
        && wr_off <= `GPR_OFF_WORD_LAST;
    wire [11:0] wr_word_idx = wr_off[13:2] - 12'h400;
    wire wr_dir = wr_hit && wr_off == `GPR_OFF_DIR;
    wire wr_mask = wr_hit && wr_off == `GPR_OFF_MASK;
    wire wr_pin = wr_hit && wr_off == `GPR_OFF_PIN;
    wire wr_mpin = wr_hit && wr_off == `GPR_OFF_MPIN;
    wire wr_set = wr_hit && wr_off == `GPR_OFF_SET;
    wire wr_clr = wr_hit && wr_off == `GPR_OFF_CLR;
    wire wr_not = wr_hit && wr_off == `GPR_OFF_NOT;
    wire wr_dirset = wr_hit && wr_off == `GPR_OFF_DIRSET;
    wire wr_dirclr = wr_hit && wr_off == `GPR_OFF_DIRCLR;
    wire wr_dirnot = wr_hit && wr_off == `GPR_OFF_DIRNOT;
    wire wr_known = wr_byte_rgn || wr_word_rgn || wr_dir || wr_mask || wr_pin || wr_mpin
        || wr_set || wr_clr || wr_not || wr_dirset || wr_dirclr || wr_dirnot;

    // Output latch update
    always_comb
    begin
        next_out_latch = out_latch;
        if (do_write && wr_byte_rgn)
        begin
            for (int l = 0; l < 4; l++)
            begin
                if (w_strb[l] && (wr_off[4:0] + l) < `GPR_NUM_PINS)
                begin
                    next_out_latch[wr_off[4:0] + l] =
                        w_data[l*8 + `GPR_PIN_LEVEL_BYTE_BIT];
                end
            end
        end
        else if (do_write && wr_word_rgn)
        begin
            if (|w_strb && wr_word_idx < `GPR_NUM_PINS)
            begin
                // Only the strobed lanes count toward the nonzero test
                next_out_latch[wr_word_idx[4:0]] = |wr_val;
            end
        end
        else if (do_write && wr_pin)
        begin
            next_out_latch = (out_latch & ~wr_bits18) | wr_val18;
        end
        else if (do_write && wr_mpin)
        begin
            next_out_latch = (out_latch & ~(wr_bits18 & ~access_mask))
                | (wr_val18 & ~access_mask);
        end
        else if (do_write && wr_set)
        begin
            next_out_latch = out_latch | wr_val18;
        end
        else if (do_write && wr_clr)
        begin
            next_out_latch = out_latch & ~wr_val18;
        end
        else if (do_write && wr_not)
        begin
            next_out_latch = out_latch ^ wr_val18;
        end
        next_out_latch = next_out_latch & impl_pins;
    end

    // Direction and mask update
    always_comb
    begin
        next_pin_direction = pin_direction;
        if (do_write && wr_dir)
        begin
            next_pin_direction = (pin_direction & ~wr_bits18) | wr_val18;
        end
        else if (do_write && wr_dirset)
        begin
            next_pin_direction = pin_direction | wr_val18;
        end
        else if (do_write && wr_dirclr)
        begin
            next_pin_direction = pin_direction & ~wr_val18;
        end
        else if (do_write && wr_dirnot)
        begin
            next_pin_direction = pin_direction ^ wr_val18;
        end
        next_pin_direction = next_pin_direction & impl_pins;
        next_access_mask = access_mask;
        if (do_write && wr_mask)
        begin
            next_access_mask = (access_mask & ~wr_bits18) | wr_val18;
        end
        next_access_mask = next_access_mask & impl_pins;
    end

    always_ff @(posedge aclk)
    begin
        out_latch <= aresetn ? next_out_latch : `GPR_OUT_RESET;
        pin_direction <= aresetn ? next_pin_direction : `GPR_DIR_RESET;
        access_mask <= aresetn ? next_access_mask : `GPR_MASK_RESET;
    end

    assign pin_output_latch = out_latch;
    assign pin_direction_out = pin_direction;

    // Write channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 32'h0000_0000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end
        else
        begin
            aw_addr <= aw_take ? s_axi_awaddr : aw_addr;
            w_data <= w_take ? s_axi_wdata : w_data;
            w_strb <= w_take ? s_axi_wstrb : w_strb;
            aw_held <= do_write ? 1'b0 : (aw_held || aw_take);
            w_held <= do_write ? 1'b0 : (w_held || w_take);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid <= 1'b0;
            bresp <= gpr_pkg::GPR_RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid <= 1'b1;
            bresp <= wr_known ? gpr_pkg::GPR_RESP_OKAY : gpr_pkg::GPR_RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            bvalid <= 1'b0;
        end
    end

    // Read decode
    wire rd_hit = addr_hit(s_axi_araddr);
    wire [13:0] rd_off = addr_off(s_axi_araddr);
    wire [11:0] rd_word_idx = rd_off[13:2] - 12'h400;
    wire [17:0] masked_port_view = pin_view & ~access_mask;
    // Write-only registers answer OKAY with zero data
    wire rd_wo = rd_hit && (rd_off == `GPR_OFF_CLR || rd_off == `GPR_OFF_NOT
        || rd_off == `GPR_OFF_DIRSET || rd_off == `GPR_OFF_DIRCLR || rd_off == `GPR_OFF_DIRNOT);

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        next_rd_hit = 1'b1;
        if (rd_hit && rd_off <= `GPR_OFF_BYTE_LAST)
        begin
            for (int l = 0; l < 4; l++)
            begin
                if ((rd_off[4:0] + l) < `GPR_NUM_PINS)
                begin
                    next_rdata[l*8 + `GPR_PIN_LEVEL_BYTE_BIT] =
                        pin_view[rd_off[4:0] + l];
                end
            end
        end
        else if (rd_hit && rd_off >= `GPR_OFF_WORD_FIRST && rd_off <= `GPR_OFF_WORD_LAST)
        begin
            if (rd_word_idx < `GPR_NUM_PINS)
            begin
                next_rdata = {32{pin_view[rd_word_idx[4:0]]}};
            end
        end
        else if (rd_hit && rd_off == `GPR_OFF_DIR)
        begin
            next_rdata = {14'h0000, pin_direction};
        end
        else if (rd_hit && rd_off == `GPR_OFF_MASK)
        begin
            next_rdata = {14'h0000, access_mask};
        end
        else if (rd_hit && rd_off == `GPR_OFF_PIN)
        begin
            next_rdata = {14'h0000, pin_view};
        end
        else if (rd_hit && rd_off == `GPR_OFF_MPIN)
        begin
            next_rdata = {14'h0000, masked_port_view};
        end
        else if (rd_hit && rd_off == `GPR_OFF_SET)
        begin
            next_rdata = {14'h0000, out_latch};
        end
        else
        begin
            next_rd_hit = rd_wo;
        end
    end

    // Read channel; data captured at the address handshake
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= gpr_pkg::GPR_RESP_OKAY;
        end
        else if (ar_take)
        begin
            rvalid <= 1'b1;
            rdata <= next_rdata;
            rresp <= next_rd_hit ? gpr_pkg::GPR_RESP_OKAY : gpr_pkg::GPR_RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            rvalid <= 1'b0;
        end
    end

    // Protection bits carry no meaning here
    wire unused_prot = ^{s_axi_awprot, s_axi_arprot};

endmodule

// File: rtl/gpr_params.svh
// Constants for the GPIO port register file: address map, field masks,
// reset values. Included by the design; holds definitions only.
`ifndef GPR_PARAMS_SVH
`define GPR_PARAMS_SVH

// Decode window
`define GPR_BASE_ADDR 32'ha000_0000
`define GPR_WIN_MASK 32'hffff_c000

// Register offsets inside the window
`define GPR_OFF_BYTE_FIRST 14'h0000
`define GPR_OFF_BYTE_LAST 14'h0011
`define GPR_OFF_WORD_FIRST 14'h1000
`define GPR_OFF_WORD_LAST 14'h1044
`define GPR_OFF_DIR 14'h2000
`define GPR_OFF_MASK 14'h2080
`define GPR_OFF_PIN 14'h2100
`define GPR_OFF_MPIN 14'h2180
`define GPR_OFF_SET 14'h2200
`define GPR_OFF_CLR 14'h2280
`define GPR_OFF_NOT 14'h2300
`define GPR_OFF_DIRSET 14'h2380
`define GPR_OFF_DIRCLR 14'h2400
`define GPR_OFF_DIRNOT 14'h2480

// Pin fields
`define GPR_NUM_PINS 18
`define GPR_LOW_PINS_IMPL 17'h1ffbf
`define GPR_PIN_LEVEL_BYTE_BIT 0

// Reset values
`define GPR_DIR_RESET 18'h00000
`define GPR_MASK_RESET 18'h00000
`define GPR_OUT_RESET 18'h00000

`endif

// File: rtl/gpr_pkg.sv
// Types shared by the GPIO port register file.
// Assumes the constants header is included where numbers are needed.
package gpr_pkg;

    typedef logic [17:0] gpr_pins_t;

    typedef enum logic [1:0] {
        GPR_RESP_OKAY = 2'h0,
        GPR_RESP_SLVERR = 2'h2
    } gpr_resp_t;

endpackage

// File: verif/gpr_pad_model.sv
// Pad model: outside drivers plus loop back of driven pins.
// Assumes the bench sets the outside level of every pin.
`timescale 1ns/1ps

module gpr_pad_model (
    // Device side
    input wire logic [17:0] pin_output_latch,
    input wire logic [17:0] pin_direction_out,
    // Outside world
    input wire logic [17:0] ext_level,
    output logic [17:0] pad_level
);
    // Output pins show their latch; no contention modelled
    assign pad_level = (pin_direction_out & pin_output_latch) | (~pin_direction_out & ext_level);
endmodule

// File: verif/gpr_port_register_file_assertions.sv
// Checker on the port register file pins.
// Bound to every instance of the design; one clock domain.
`timescale 1ns/1ps

module gpr_port_register_file_assertions (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Pads
    input wire logic [17:0] pin_output_latch,
    input wire logic [17:0] pin_direction_out
);
    logic [1:0] reg_area;
    wire rd_ok = s_axi_rvalid && s_axi_rresp == 2'h0;

    // Area of the read in flight
    always_ff @(posedge aclk)
    begin
        if (s_axi_arvalid && s_axi_arready)
            reg_area <= s_axi_araddr[13:12];
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_RST_CLEAR: assert property ($rose(aresetn) |->
        pin_direction_out == 18'h0 && pin_output_latch == 18'h0) else $error("reset state");
    AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read dropped");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address taken early");
    AST_WR_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("response dropped");
    AST_BYTE_RSV: assert property (rd_ok && reg_area == 2'h0 |->
        (s_axi_rdata & 32'hfefe_fefe) == 32'h0) else $error("byte upper bits");
    AST_WORD_ALL: assert property (rd_ok && reg_area == 2'h1 |->
        s_axi_rdata inside {32'h0, 32'hffff_ffff}) else $error("word value");
    AST_HIGH_ZERO: assert property (rd_ok && reg_area == 2'h2 |->
        s_axi_rdata[31:18] == 14'h0) else $error("reserved bits");
    AST_LATCH_QUIET: assert property (!$rose(s_axi_bvalid) |->
        $stable(pin_output_latch)) else $error("latch moved");
    AST_DIR_QUIET: assert property (!$rose(s_axi_bvalid) |->
        $stable(pin_direction_out)) else $error("direction moved");
    AST_PIN6_ABSENT: assert property (pin_output_latch[6] == 1'b0 &&
        pin_direction_out[6] == 1'b0) else $error("pin 6 bits");
endmodule

bind gpr_port_register_file gpr_port_register_file_assertions
    gpr_port_register_file_assertions_inst (
    .aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .pin_output_latch, .pin_direction_out
);

// File: verif/test_gpio_port_register_file.sv
// Self-checking bench for the port register file.
// Assumes design, pad model and checker are compiled first.
`timescale 1ns/1ps
`include "gpr_params.svh"

module test_gpio_port_register_file;
    localparam logic [17:0] IMPL = 18'h3ffbf;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [31:0] s_axi_araddr = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [17:0] pad_level, pin_output_latch, pin_direction_out, v;
    logic [17:0] ext = 18'h2a5a5;
    logic [17:0] ana = 18'h0;
    logic [17:0] el = 18'h0;
    logic [17:0] ed = 18'h0;
    logic slow = 1'b0;
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;

    always #10 aclk = ~aclk;

    gpr_port_register_file gpr_port_register_file_inst (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .pad_level, .pad_analog_sel(ana), .pin_output_latch,
        .pin_direction_out
    );

    gpr_pad_model gpr_pad_model_inst (
        .pin_output_latch, .pin_direction_out, .ext_level(ext), .pad_level
    );

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Hang guard, well above the few hundred cycles needed
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            fail_count++;
            final_report();
        end
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [15:0] o, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= `GPR_BASE_ADDR + o;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= !slow;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && !s_axi_bready)
                s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid === 1'b1 && s_axi_bready));
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask

    // Waits first so pad changes pass the input synchroniser
    task automatic rd(input logic [15:0] o, input logic [31:0] e, input logic [1:0] er);
        repeat (3) @(posedge aclk);
        s_axi_araddr <= `GPR_BASE_ADDR + o;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= !slow;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && !s_axi_rready)
                s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid === 1'b1 && s_axi_rready));
        s_axi_rready <= 1'b0;
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        chk("rdata", e, s_axi_rdata);
    endtask

    function automatic logic [17:0] pv();
        return ((ed & el) | (~ed & ext)) & IMPL;
    endfunction

    function automatic logic [31:0] bw(input int g);
        logic [31:0] r;
        logic [17:0] p;
        r = 32'h0;
        p = pv();
        for (int l = 0; l < 4; l++)
            if (4 * g + l < 18)
                r[8 * l] = p[4 * g + l];
        return r;
    endfunction

    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(16'h2000, 32'h0, 2'h0);
        rd(16'h2080, 32'h0, 2'h0);
        rd(16'h2200, 32'h0, 2'h0);
        rd(16'h2100, {14'h0, pv()}, 2'h0);
        v = pv();
        for (int g = 0; g < 5; g++)
            rd(16'(4 * g), bw(g), 2'h0);
        for (int n = 0; n < 18; n++)
            rd(16'h1000 + 16'(4 * n), {32{v[n]}}, 2'h0);
        ana <= 18'h00001;
        @(posedge aclk);
        rd(16'h1000, 32'h0, 2'h0);
        rd(16'h0000, bw(0) & 32'hffff_fffe, 2'h0);
        ana <= 18'h0;
        $display("test pin reads done");
        slow = 1'b1;
        wr(16'h0000, 32'h0302_0100, 4'hf, 2'h0);
        wr(16'h0008, 32'h00ff_0001, 4'h4, 2'h0);
        el = 18'h0040a;
        rd(16'h2200, {14'h0, el}, 2'h0);
        slow = 1'b0;
        wr(16'h1010, 32'h0000_0100, 4'hf, 2'h0);
        wr(16'h1004, 32'h0, 4'hf, 2'h0);
        wr(16'h2280, 32'h8, 4'hf, 2'h0);
        wr(16'h2300, 32'h3, 4'hf, 2'h0);
        wr(16'h2200, 32'hfffe_0040, 4'hf, 2'h0);
        el = 18'h20413;
        rd(16'h2200, {14'h0, el}, 2'h0);
        chk("latch", {14'h0, el}, {14'h0, pin_output_latch});
        $display("test latch writes done");
        wr(16'h2080, 32'hf, 4'hf, 2'h0);
        rd(16'h2080, 32'hf, 2'h0);
        wr(16'h2180, 32'h0, 4'hf, 2'h0);
        el = 18'h00003;
        rd(16'h2180, {14'h0, pv() & 18'h3fff0}, 2'h0);
        wr(16'h2100, 32'h0003_ffff, 4'hf, 2'h0);
        el = IMPL;
        rd(16'h2200, {14'h0, el}, 2'h0);
        $display("test mask done");
        rd(16'h2280, 32'h0, 2'h0);
        rd(16'h2480, 32'h0, 2'h0);
        wr(16'h2004, 32'hffff_ffff, 4'hf, 2'h2);
        rd(16'h2504, 32'h0, 2'h2);
        rd(16'h1048, 32'h0, 2'h2);
        $display("test map done");
        wr(16'h2380, 32'h0003_ffff, 4'hf, 2'h0);
        wr(16'h2400, 32'hf, 4'hf, 2'h0);
        wr(16'h2480, 32'h30, 4'hf, 2'h0);
        ed = 18'h3ff80;
        rd(16'h2000, {14'h0, ed}, 2'h0);
        wr(16'h2000, 32'h0, 4'h1, 2'h0);
        ed = 18'h3ff00;
        chk("dir", {14'h0, ed}, {14'h0, pin_direction_out});
        wr(16'h0000, 32'h0, 4'h3, 2'h0);
        el = IMPL & 18'h3fffc;
        rd(16'h2200, {14'h0, el}, 2'h0);
        rd(16'h2100, {14'h0, pv()}, 2'h0);
        $display("test direction done");
        final_report();
    end
endmodule
